// file: pkg/cst_pkg.sv
// Package for the current sense and telemetry processor.
// Assumes a single 25 MHz clock and a plain strobe register port.
package cst_pkg;
    localparam int CLK_MHZ = 25;
    localparam int FAST_MHZ = 100;
    localparam int TEL_RATE_KHZ = 1000;
    localparam int TEL_DIV = (CLK_MHZ * 1000) / TEL_RATE_KHZ;
    localparam int BLANK_MAX_NS = 280;
    localparam int CLK_PERIOD_NS = 40;
    localparam int BLANK_MAX_CYC = BLANK_MAX_NS / CLK_PERIOD_NS;
    localparam int DAC_LEVELS = 640;
    localparam int HIGH_GAIN_UV = 100;
    localparam int LOW_GAIN_UV = 1450;
    localparam int TEL_STEP_NV = 2344000;
    localparam int CURRENT_MONITOR_OUTPUT_SPAN_UA = 640;
    localparam int CURRENT_MONITOR_OUTPUT_ZERO_UA = 320;
    localparam int THERM_BIAS_UA = 100;
    localparam int NTC_KOHM = 47;
    localparam int PAR_KOHM = 12;
    localparam int TEL_SLOTS = 8;
    localparam int TEL_USABLE = 6;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BLANK = 8'h04;
    localparam logic [7:0] REG_OCLIM = 8'h08;
    localparam logic [7:0] REG_UCLIM = 8'h0C;
    localparam logic [7:0] REG_PKLIM = 8'h10;
    localparam logic [7:0] REG_IINLIM = 8'h14;
    localparam logic [7:0] REG_SHARE = 8'h18;
    localparam logic [7:0] REG_CLAMP = 8'h1C;
    localparam logic [7:0] REG_SEQ = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;
    localparam logic [7:0] REG_IAVG = 8'h28;
    localparam logic [7:0] REG_TEMP = 8'h2C;
    localparam logic [7:0] REG_TEL = 8'h30;
    localparam logic [7:0] REG_LUT = 8'h34;
    localparam logic [7:0] REG_CURRENT_MONITOR_OUTPUT = 8'h38;
    localparam logic [7:0] REG_ADJ = 8'h3C;
    // CTRL fields
    localparam int CTRL_GAIN_LOW = 0;
    localparam int CTRL_IPS = 1;
    localparam int CTRL_PRIMARY = 2;
    localparam int CTRL_COPPER = 3;
    localparam int CTRL_AUTO_SEQ = 4;
    localparam int CTRL_USER_LUT = 5;
    localparam int CTRL_PEAK_CURRENT_CONTROL = 6;
    localparam int CTRL_TRI_A = 7;
    localparam int CTRL_TRI_B = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] BLANK_RST = 32'h0000_0000;
    localparam logic [31:0] SEQ_RST = 32'h0054_3210;
    localparam logic [12:0] CU_TC_Q12 = 13'h0010;
    typedef enum logic [2:0] {
        CST_IDLE = 3'b001,
        CST_LEB = 3'b010,
        CST_TEB = 3'b100
    } cst_blank_type;
endpackage : cst_pkg

// file: rtl/cst_proc.sv
// Current sense, telemetry, monitor DAC, sharing and thermistor processing.
// Assumes analog comparators and converters sit outside; one 25 MHz clock.
//
// Contract
// - Tracking converter result interpolated to 13 bits
// - Converter at 25 MHz, peak check at 100 MHz
// - Gain select: 100 uV or 1.45 mV step
// - Reference ground except integrated power stage mode
// - Feedback DAC 640 levels with offset codes
// - Five comparators give signed error +-1,3,5
// - Estimator rebuilds secondary or primary current
// - Copper sensing corrected for temperature before faults
// - Ignore samples in 0..280 ns blanking windows
// - Average samples, report once per cycle
// - Predict DC and ripple, merge with measurement
// - Over/under current faults, input OC in peak mode
// - Only two PWM outputs have native tri-state
// - Telemetry results 9 bits at 1 MHz
// - Eight slots, six usable, user or auto order
// - Monitor DAC 6 bits plus dither carry
// - Monitor current 320 midscale, span 640
// - No share adjustment inside dead zone
// - Clamp adjustment, fault at clamp outside dead zone
// - Thermistor biased 100 uA, result feeds compensation
// - Built-in or user temperature lookup table
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module cst_proc import cst_pkg::*; #(
    parameter int DAC_W = 10,
    parameter int LUT_DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [4:0] quant_cmp_in,
    input wire logic pwm_in,
    input wire logic peak_cmp_in,
    input wire logic [8:0] tel_data_in,
    input wire logic tel_valid_in,
    input wire logic [8:0] share_avg_in,
    output logic [DAC_W-1:0] fb_dac_out,
    output logic gain_low_out,
    output logic ref_cm_out,
    output logic [2:0] tel_chan_out,
    output logic tel_start_out,
    output logic [5:0] current_monitor_output_code_out,
    output logic current_monitor_output_lsb_out,
    output logic therm_bias_out,
    output logic tri_a_en_out,
    output logic tri_b_en_out,
    output logic oc_fault_out,
    output logic uc_fault_out,
    output logic iin_fault_out,
    output logic peak_limit_out,
    output logic share_fault_out
);
    logic [31:0] ctrl_r, blank_r, oclim_r, uclim_r, pklim_r, iinlim_r, share_r, clamp_r, seq_r;
    logic [8:0] lut_r [LUT_DEPTH];
    logic [1:0] sync_pwm_r;
    logic [2:0] pk_sync_r;
    logic pwm_q_r;
    logic [DAC_W-1:0] track_r;
    logic [12:0] est_r, slope_r, corr_r;
    logic [3:0] blank_cnt_r;
    cst_blank_type bst_r;
    logic [17:0] acc_r;
    logic [4:0] n_r;
    logic [12:0] avg_r;
    logic [4:0] tel_div_r;
    logic [2:0] slot_r;
    logic [8:0] tel_res_r [TEL_SLOTS];
    logic [8:0] temp_r;
    logic [3:0] dith_r;
    logic [9:0] current_monitor_output_r;
    logic signed [9:0] adj_r;
    logic oc_r, uc_r, iin_r, pk_r, sf_r;

    wire logic pwm_edge = sync_pwm_r[1] ^ pwm_q_r;
    wire logic [DAC_W-1:0] dac_max = DAC_W'(DAC_LEVELS - 1);

    // Thermometer of five comparators to signed error
    logic signed [3:0] err;
    always_comb begin
        unique case (quant_cmp_in)
            5'b00000: err = -4'sd5;
            5'b00001: err = -4'sd3;
            5'b00011: err = -4'sd1;
            5'b00111: err = 4'sd1;
            5'b01111: err = 4'sd3;
            default: err = 4'sd5;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r <= CTRL_RST;
            blank_r <= BLANK_RST;
            oclim_r <= 32'h0000_1FFF;
            uclim_r <= 32'h0000_0000;
            pklim_r <= 32'h0000_1FFF;
            iinlim_r <= 32'h0000_1FFF;
            share_r <= 32'h0000_0000;
            clamp_r <= 32'h0000_0000;
            seq_r <= SEQ_RST;
        end else if (wr_in) begin
            unique case (addr_in)
                REG_CTRL: ctrl_r <= wdata_in;
                REG_BLANK: blank_r <= wdata_in;
                REG_OCLIM: oclim_r <= wdata_in;
                REG_UCLIM: uclim_r <= wdata_in;
                REG_PKLIM: pklim_r <= wdata_in;
                REG_IINLIM: iinlim_r <= wdata_in;
                REG_SHARE: share_r <= wdata_in;
                REG_CLAMP: clamp_r <= wdata_in;
                REG_SEQ: seq_r <= wdata_in;
                default: ;
            endcase
        end
    end

    // User table: LUT register carries index in [19:16], value in [8:0]
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < LUT_DEPTH; i++) lut_r[i] <= 9'h000;
        end else if (wr_in && addr_in == REG_LUT) begin
            lut_r[wdata_in[19:16]] <= wdata_in[8:0];
        end
    end

    // Pin inputs: three stages, change accepted when last two agree
    logic pwm_s0_r;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pwm_s0_r <= 1'b0;
            sync_pwm_r <= 2'b00;
            pwm_q_r <= 1'b0;
            pk_sync_r <= 3'b000;
        end else begin
            pwm_s0_r <= pwm_in;
            sync_pwm_r <= {sync_pwm_r[0], pwm_s0_r};
            if (sync_pwm_r[1] == sync_pwm_r[0]) pwm_q_r <= sync_pwm_r[1];
            pk_sync_r <= {pk_sync_r[1:0], peak_cmp_in};
        end
    end
    wire logic pwm_chg = (sync_pwm_r[1] == sync_pwm_r[0]) && pwm_edge;

    // Tracking integrator and feedback DAC code
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            track_r <= DAC_W'(DAC_LEVELS / 2);
        end else begin
            if ($signed({1'b0, track_r}) + err > $signed({1'b0, dac_max}))
                track_r <= dac_max;
            else if ($signed({1'b0, track_r}) + err < 0)
                track_r <= '0;
            else
                track_r <= DAC_W'($signed({1'b0, track_r}) + err);
        end
    end

    // Estimator: slope learned from error, prediction merged with track
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            est_r <= 13'h0000;
            slope_r <= 13'h0000;
        end else begin
            if (pwm_chg) slope_r <= 13'h0000;
            else slope_r <= slope_r + 13'(err);
            // Prediction follows pwm state; primary only ramps while on
            if (ctrl_r[CTRL_PRIMARY] && !pwm_q_r)
                est_r <= 13'h0000;
            else
                // One spare bit so the merge sum cannot wrap
                est_r <= 13'((14'({3'b000, track_r} << 3) + 14'(est_r)
                    + 14'(slope_r >>> 4)) >> 1);
        end
    end

    // Blanking windows around each edge
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bst_r <= CST_IDLE;
            blank_cnt_r <= 4'h0;
        end else if (pwm_chg) begin
            bst_r <= pwm_q_r ? CST_TEB : CST_LEB;
            blank_cnt_r <= pwm_q_r ? blank_r[7:4] : blank_r[3:0];
        end else if (bst_r != CST_IDLE) begin
            if (blank_cnt_r == 4'h0 || blank_cnt_r > 4'(BLANK_MAX_CYC)) bst_r <= CST_IDLE;
            else blank_cnt_r <= blank_cnt_r - 4'h1;
        end
    end
    wire logic sample_ok = (bst_r == CST_IDLE) && !pwm_chg;

    // Copper compensation
    wire logic [25:0] comp_prod = est_r * (13'h1000 + 13'(temp_r * CU_TC_Q12 >> 4));
    always_ff @(posedge clk_in) begin
        if (reset_in) corr_r <= 13'h0000;
        else corr_r <= ctrl_r[CTRL_COPPER] ? comp_prod[24:12] : est_r;
    end

    // Per-cycle average, reported on rising pwm edge
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            acc_r <= 18'h00000;
            n_r <= 5'h00;
            avg_r <= 13'h0000;
        end else if (pwm_chg && !pwm_q_r) begin
            avg_r <= (n_r == 5'h00) ? avg_r : 13'(acc_r / n_r);
            acc_r <= 18'h00000;
            n_r <= 5'h00;
        end else if (sample_ok && n_r != 5'h1F) begin
            acc_r <= acc_r + 18'(corr_r);
            n_r <= n_r + 5'h01;
        end
    end

    // Faults; the 100 MHz comparator result arrives as a held level
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            oc_r <= 1'b0;
            uc_r <= 1'b0;
            iin_r <= 1'b0;
            pk_r <= 1'b0;
        end else begin
            oc_r <= avg_r > oclim_r[12:0];
            uc_r <= avg_r < uclim_r[12:0];
            iin_r <= ctrl_r[CTRL_PEAK_CURRENT_CONTROL] && corr_r > iinlim_r[12:0];
            pk_r <= (pk_sync_r[2] && pk_sync_r[1]) || corr_r > pklim_r[12:0];
        end
    end

    // Telemetry sequencing at 1 MHz
    wire logic [2:0] next_slot = ctrl_r[CTRL_AUTO_SEQ] ?
        ((slot_r >= 3'(TEL_USABLE - 1)) ? 3'h0 : slot_r + 3'h1) : 3'(slot_r + 3'h1) % 3'(TEL_USABLE);
    wire logic [2:0] chan = ctrl_r[CTRL_AUTO_SEQ] ? slot_r : seq_r[slot_r*4 +: 3];
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tel_div_r <= 5'h00;
            slot_r <= 3'h0;
            tel_start_out <= 1'b0;
            tel_chan_out <= 3'h0;
        end else begin
            tel_start_out <= tel_div_r == 5'h00;
            if (tel_div_r == 5'(TEL_DIV - 1)) begin
                tel_div_r <= 5'h00;
                slot_r <= next_slot;
                tel_chan_out <= chan;
            end else begin
                tel_div_r <= tel_div_r + 5'h01;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < TEL_SLOTS; i++) tel_res_r[i] <= 9'h000;
        end else if (tel_valid_in && tel_chan_out < 3'(TEL_USABLE)) begin
            tel_res_r[tel_chan_out] <= tel_data_in;
        end
    end

    // Thermistor channel 0: fixed table slope or user table
    always_ff @(posedge clk_in) begin
        if (reset_in) temp_r <= 9'h000;
        else if (ctrl_r[CTRL_USER_LUT]) temp_r <= lut_r[tel_res_r[0][8:5]];
        else temp_r <= 9'h1FF - tel_res_r[0];
    end

    // Monitor DAC with dither; midscale at zero load
    wire logic [9:0] current_monitor_output_val =
        10'(10'h200 + ((17'(avg_r) * 17'(share_r[23:20])) >> 4));
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            current_monitor_output_r <= 10'h200;
            dith_r <= 4'h0;
            current_monitor_output_lsb_out <= 1'b0;
            current_monitor_output_code_out <= 6'h20;
        end else if (pwm_chg && !pwm_q_r) begin
            current_monitor_output_r <= current_monitor_output_val;
            {current_monitor_output_lsb_out, dith_r} <= {1'b0, dith_r} + {1'b0, current_monitor_output_r[3:0]};
            current_monitor_output_code_out <= current_monitor_output_r[9:4];
        end
    end

    // Sharing loop with dead zone and clamps
    wire logic signed [10:0] share_err = $signed({2'b00, current_monitor_output_r[9:1]}) - $signed({2'b00, share_avg_in});
    wire logic [10:0] share_mag = share_err[10] ? -share_err : share_err;
    wire logic outside = share_mag > {2'b00, share_r[8:0]};
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            adj_r <= 10'sh000;
            sf_r <= 1'b0;
        end else if (pwm_chg && !pwm_q_r) begin
            if (outside) begin
                if (share_err[10] && adj_r < $signed(clamp_r[9:0]))
                    adj_r <= adj_r + 10'sh001;
                else if (!share_err[10] && adj_r > -$signed(clamp_r[25:16]))
                    adj_r <= adj_r - 10'sh001;
            end
            sf_r <= outside && (adj_r >= $signed(clamp_r[9:0]) ||
                    adj_r <= -$signed(clamp_r[25:16]));
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            fb_dac_out <= '0;
            gain_low_out <= 1'b0;
            ref_cm_out <= 1'b0;
            therm_bias_out <= 1'b0;
            tri_a_en_out <= 1'b0;
            tri_b_en_out <= 1'b0;
            oc_fault_out <= 1'b0;
            uc_fault_out <= 1'b0;
            iin_fault_out <= 1'b0;
            peak_limit_out <= 1'b0;
            share_fault_out <= 1'b0;
        end else begin
            fb_dac_out <= track_r;
            gain_low_out <= ctrl_r[CTRL_GAIN_LOW];
            ref_cm_out <= ctrl_r[CTRL_IPS];
            therm_bias_out <= 1'b1;
            // Other outputs need firmware forcing to high impedance
            tri_a_en_out <= ctrl_r[CTRL_TRI_A];
            tri_b_en_out <= ctrl_r[CTRL_TRI_B];
            oc_fault_out <= oc_r;
            uc_fault_out <= uc_r;
            iin_fault_out <= iin_r;
            peak_limit_out <= pk_r;
            share_fault_out <= sf_r;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            unique case (addr_in)
                REG_CTRL: rdata_out <= ctrl_r;
                REG_BLANK: rdata_out <= blank_r;
                REG_OCLIM: rdata_out <= oclim_r;
                REG_UCLIM: rdata_out <= uclim_r;
                REG_PKLIM: rdata_out <= pklim_r;
                REG_IINLIM: rdata_out <= iinlim_r;
                REG_SHARE: rdata_out <= share_r;
                REG_CLAMP: rdata_out <= clamp_r;
                REG_SEQ: rdata_out <= seq_r;
                REG_STATUS: rdata_out <= {27'h0, sf_r, pk_r, iin_r, uc_r, oc_r};
                REG_IAVG: rdata_out <= {19'h0, avg_r};
                REG_TEMP: rdata_out <= {23'h0, temp_r};
                REG_TEL: rdata_out <= {23'h0, tel_res_r[wdata_in[2:0]]};
                REG_CURRENT_MONITOR_OUTPUT: rdata_out <= {22'h0, current_monitor_output_r};
                REG_ADJ: rdata_out <= {{22{adj_r[9]}}, adj_r};
                default: rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // Checks
    property p_track_step;
        @(posedge clk_in) disable iff (reset_in)
        (track_r > 10'd5 && track_r < 10'd630) |=>
            (10'(track_r - $past(track_r)) inside
                {10'h001, 10'h003, 10'h005, 10'h3FF, 10'h3FD, 10'h3FB});
    endproperty
    a_track_step: assert property (p_track_step) else $error("track step illegal");
    property p_dac_range;
        @(posedge clk_in) disable iff (reset_in) track_r <= dac_max;
    endproperty
    a_dac_range: assert property (p_dac_range) else $error("dac code over range");
    property p_blank_restart;
        @(posedge clk_in) disable iff (reset_in) pwm_chg |=> bst_r != CST_IDLE;
    endproperty
    a_blank_restart: assert property (p_blank_restart) else $error("blank not restarted");
    property p_blank_len;
        @(posedge clk_in) disable iff (reset_in) pwm_chg |-> ##[1:9] bst_r == CST_IDLE || pwm_chg;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blank too long");
    property p_tel_rate;
        @(posedge clk_in) disable iff (reset_in) tel_start_out |=> !tel_start_out [*8];
    endproperty
    a_tel_rate: assert property (p_tel_rate) else $error("telemetry rate wrong");
    property p_tel_slot;
        @(posedge clk_in) disable iff (reset_in) slot_r < 3'(TEL_USABLE);
    endproperty
    a_tel_slot: assert property (p_tel_slot) else $error("unusable slot");
    property p_share_dead;
        @(posedge clk_in) disable iff (reset_in) (pwm_chg && !pwm_q_r && !outside) |=> $stable(adj_r);
    endproperty
    a_share_dead: assert property (p_share_dead) else $error("adjust in dead zone");
    property p_iin_peak_current_control;
        @(posedge clk_in) disable iff (reset_in) !ctrl_r[CTRL_PEAK_CURRENT_CONTROL] |=> ##1 !iin_fault_out;
    endproperty
    a_iin_peak_current_control: assert property (p_iin_peak_current_control) else $error("input fault outside peak mode");
endmodule : cst_proc

// file: verification/cst_afe_model.sv
// Behavioural analog current sense and telemetry front end for cst_proc.
// Assumes the device clock; the bench sets the sensed current and peak level.
`timescale 1ns/100ps
module cst_afe_model #(
    parameter int CONV_CYC = 10
) (
    input wire logic clk_in,
    input wire logic [9:0] target_in,
    input wire logic peak_in,
    input wire logic [9:0] fb_dac_in,
    input wire logic [2:0] tel_chan_in,
    input wire logic tel_start_in,
    output logic [4:0] quant_cmp_out,
    output logic peak_cmp_out,
    output logic [8:0] tel_data_out,
    output logic tel_valid_out
);
    int diff;
    int conv_cnt;
    logic [2:0] chan_r;
    initial begin
        conv_cnt = 0;
        chan_r = 3'h0;
        tel_data_out = 9'h000;
        tel_valid_out = 1'b0;
    end
    // Thermometer of the tracking error, five comparators
    always_comb begin
        diff = int'(target_in) - int'(fb_dac_in);
        if (diff <= -4) quant_cmp_out = 5'h00;
        else if (diff <= -2) quant_cmp_out = 5'h01;
        else if (diff < 0) quant_cmp_out = 5'h03;
        else if (diff < 2) quant_cmp_out = 5'h07;
        else if (diff < 4) quant_cmp_out = 5'h0F;
        else quant_cmp_out = 5'h1F;
    end
    assign peak_cmp_out = peak_in;
    // Result tagged by channel; data lines churn outside the valid cycle
    always @(posedge clk_in) begin
        tel_valid_out <= 1'b0;
        tel_data_out <= ~tel_data_out;
        if (tel_start_in) begin
            chan_r <= tel_chan_in;
            conv_cnt <= CONV_CYC;
        end else if (conv_cnt > 0) begin
            conv_cnt <= conv_cnt - 1;
            if (conv_cnt == 1) begin
                tel_valid_out <= 1'b1;
                tel_data_out <= {chan_r, 6'h2A};
            end
        end
    end
endmodule : cst_afe_model

// file: verification/cst_proc_tb.sv
// Self-checking bench for cst_proc with a behavioural front end model.
// Assumes one 25 MHz clock and the strobe register port of the design.
`timescale 1ns/100ps
module cst_proc_tb import cst_pkg::*;;
    logic clk_in, reset_in, wr_in, rd_in, pwm_in, peak_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata_out, got;
    logic [4:0] quant_cmp_in;
    logic peak_cmp_in, tel_valid_in, gain_low_out, ref_cm_out, tel_start_out;
    logic [8:0] tel_data_in, share_avg_in;
    logic [9:0] fb_dac_out, target;
    logic [2:0] tel_chan_out;
    logic [5:0] current_monitor_output_code_out;
    logic current_monitor_output_lsb_out, therm_bias_out, tri_a_en_out, tri_b_en_out;
    logic oc_fault_out, uc_fault_out, iin_fault_out, peak_limit_out, share_fault_out;
    int err_count, comparisons, cycles, pwm_cnt;

    cst_proc DUT (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .quant_cmp_in(quant_cmp_in), .pwm_in(pwm_in), .peak_cmp_in(peak_cmp_in),
        .tel_data_in(tel_data_in), .tel_valid_in(tel_valid_in),
        .share_avg_in(share_avg_in), .fb_dac_out(fb_dac_out),
        .gain_low_out(gain_low_out), .ref_cm_out(ref_cm_out),
        .tel_chan_out(tel_chan_out), .tel_start_out(tel_start_out),
        .current_monitor_output_code_out(current_monitor_output_code_out), .current_monitor_output_lsb_out(current_monitor_output_lsb_out),
        .therm_bias_out(therm_bias_out), .tri_a_en_out(tri_a_en_out),
        .tri_b_en_out(tri_b_en_out), .oc_fault_out(oc_fault_out),
        .uc_fault_out(uc_fault_out), .iin_fault_out(iin_fault_out),
        .peak_limit_out(peak_limit_out), .share_fault_out(share_fault_out));

    cst_afe_model AFE (.clk_in(clk_in), .target_in(target), .peak_in(peak_in),
        .fb_dac_in(fb_dac_out), .tel_chan_in(tel_chan_out),
        .tel_start_in(tel_start_out), .quant_cmp_out(quant_cmp_in),
        .peak_cmp_out(peak_cmp_in), .tel_data_out(tel_data_in),
        .tel_valid_out(tel_valid_in));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // Switching period of 40 clock cycles
    always @(posedge clk_in) begin
        pwm_cnt <= (pwm_cnt == 19) ? 0 : pwm_cnt + 1;
        if (pwm_cnt == 19) pwm_in <= ~pwm_in;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        // Extra edge so registered outputs have followed the write
        @(posedge clk_in);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] sel);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        wdata_in <= sel;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask : rd

    task automatic t_reset();
        check({26'h0, current_monitor_output_code_out}, 32'h20);
        check({31'h0, therm_bias_out}, 32'h1);
        check({27'h0, oc_fault_out, uc_fault_out, iin_fault_out, peak_limit_out,
            share_fault_out}, 32'h0);
    endtask : t_reset

    task automatic t_regs();
        wr(REG_CTRL, 32'h0000_0183);
        check({28'h0, gain_low_out, ref_cm_out, tri_a_en_out, tri_b_en_out}, 32'hF);
        rd(REG_CTRL, 32'h0);
        check(got, 32'h0000_0183);
        @(posedge clk_in);
        #1 check(rdata_out, 32'h0);
        wr(REG_CTRL, 32'h0);
        check({30'h0, gain_low_out, ref_cm_out}, 32'h0);
        wr(REG_BLANK, 32'h0000_0075);
        rd(REG_BLANK, 32'h0);
        check(got, 32'h0000_0075);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        check(got, 32'h0);
    endtask : t_regs

    task automatic t_tel_data();
        repeat (200) @(posedge clk_in);
        for (int ch = 0; ch < TEL_USABLE; ch++) begin
            rd(REG_TEL, ch);
            check({23'h0, got[8:0]}, {23'h0, ch[2:0], 6'h2A});
        end
        // Slot 0 holds 0x02A, so the user table is indexed at entry 1
        wr(REG_LUT, 32'h0001_00AB);
        wr(REG_CTRL, 32'h0000_0020);
        rd(REG_TEMP, 32'h0);
        check(got, 32'h0000_00AB);
        wr(REG_CTRL, 32'h0);
    endtask : t_tel_data

    task automatic t_tel_seq(input logic [31:0] seq);
        int gap, pos;
        logic [2:0] prev;
        wr(REG_SEQ, seq);
        for (int k = 0; k < 8; k++) begin
            gap = 0;
            do begin
                @(posedge clk_in);
                #1 gap++;
            end while (tel_start_out !== 1'b1 && gap < 100);
            if (k > 1) begin
                check(gap, TEL_DIV);
                pos = 0;
                for (int s = 0; s < TEL_USABLE; s++) if (seq[s*4 +: 3] == prev) pos = s;
                check(tel_chan_out, seq[((pos + 1) % TEL_USABLE)*4 +: 3]);
            end
            prev = tel_chan_out;
        end
    endtask : t_tel_seq

    task automatic t_current();
        int n;
        target = 10'd400;
        repeat (1500) @(posedge clk_in);
        #1 check((fb_dac_out > 10'd392 && fb_dac_out < 10'd408), 32'h1);
        wr(REG_OCLIM, 32'h1);
        for (n = 0; n < 3000 && oc_fault_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        check(oc_fault_out, 32'h1);
        rd(REG_STATUS, 32'h0);
        check(got[0], 32'h1);
        wr(REG_OCLIM, 32'h1FFF);
        wr(REG_UCLIM, 32'h1FFF);
        for (n = 0; n < 3000 && uc_fault_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        check(uc_fault_out, 32'h1);
        wr(REG_IINLIM, 32'h1);
        wr(REG_CTRL, 32'h0000_0040);
        for (n = 0; n < 8 && iin_fault_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        check(iin_fault_out, 32'h1);
        wr(REG_CTRL, 32'h0);
        @(posedge clk_in);
        #1 check(iin_fault_out, 32'h0);
        peak_in <= 1'b1;
        for (n = 0; n < 8 && peak_limit_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        #1 check(peak_limit_out, 32'h1);
        peak_in <= 1'b0;
    endtask : t_current

    task automatic t_share();
        wr(REG_SHARE, 32'h0000_0010);
        wr(REG_CLAMP, 32'h0003_0003);
        @(posedge clk_in);
        share_avg_in <= 9'h180;
        repeat (300) @(posedge clk_in);
        rd(REG_ADJ, 32'h0);
        check(got, 32'h3);
        check(share_fault_out, 32'h1);
        @(posedge clk_in);
        share_avg_in <= 9'h108;
        repeat (100) @(posedge clk_in);
        rd(REG_ADJ, 32'h0);
        check(got, 32'h3);
        check(share_fault_out, 32'h0);
        check({25'h0, current_monitor_output_code_out, current_monitor_output_lsb_out}, 32'h40);
    endtask : t_share

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    initial begin
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        pwm_cnt = 0;
        reset_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        pwm_in = 1'b0;
        peak_in = 1'b0;
        target = 10'h000;
        share_avg_in = 9'h100;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        #1 t_reset();
        t_regs();
        t_tel_data();
        t_tel_seq(32'h0001_2345);
        t_current();
        t_share();
        test_done();
    end
endmodule : cst_proc_tb
